// ===== common/cnm_cfg.svh
// Constants for the node monitor: identifiers, codes, register offsets and timing.
`ifndef CNM_CFG_SVH
`define CNM_CFG_SVH
// ==========================================================================
// Timing
`define CNM_CLK_NS 8
`define CNM_TICK_NS 1000000
`define CNM_TICK_CYC (`CNM_TICK_NS / `CNM_CLK_NS)
// ==========================================================================
// Identifiers and payload bytes
`define CNM_ID_NMT 11'h000
`define CNM_ID_EMCY_BASE 11'h080
`define CNM_ID_TPDO_BASE 11'h180
`define CNM_ID_RPDO_BASE 11'h200
`define CNM_ID_GUARD_BASE 11'h700
`define CNM_BOOT_BYTE 8'h00
`define CNM_MAX_DLC 4'h8
`define CNM_EMCY_CODE 16'h1000
// ==========================================================================
// State codes and command specifiers
`define CNM_CODE_BOOT 7'h00
`define CNM_CODE_STOP 7'h04
`define CNM_CODE_OPER 7'h05
`define CNM_CODE_PREOP 7'h7F
`define CNM_CS_START 8'h01
`define CNM_CS_STOP 8'h02
`define CNM_CS_PREOP 8'h80
`define CNM_CS_RST_NODE 8'h81
`define CNM_CS_RST_COMM 8'h82
// ==========================================================================
// Dictionary indices mirrored by the registers
`define CNM_IDX_GUARD 16'h100C
`define CNM_IDX_LIFE 16'h100D
`define CNM_IDX_RPDO_FIRST 16'h1400
`define CNM_IDX_RPDO_LAST 16'h15FF
`define CNM_IDX_TPDO_FIRST 16'h1800
`define CNM_IDX_TPDO_LAST 16'h19FF
// ==========================================================================
// Register word offsets and fields
`define CNM_REG_CTRL 4'h0
`define CNM_REG_STATUS 4'h1
`define CNM_REG_GUARD 4'h2
`define CNM_REG_LIFE 4'h3
`define CNM_REG_HB 4'h4
`define CNM_REG_TPDO_ID 4'h5
`define CNM_REG_TPDO_LO 4'h6
`define CNM_REG_TPDO_HI 4'h7
`define CNM_REG_TPDO_CTL 4'h8
`define CNM_REG_RPDO_ID 4'h9
`define CNM_REG_RPDO_LO 4'hA
`define CNM_REG_RPDO_HI 4'hB
`define CNM_COBID_OFF_BIT 31
`define CNM_TPDO_SEND_BIT 8
`endif

// ===== common/cnm_pkg.sv
// Types shared by both ends of the node monitor.
package cnm_pkg;
`include "cnm_cfg.svh"
	// ==========================================================================
	// Network states and frames
	typedef enum logic [1:0] {NS_INIT, NS_PREOP, NS_OPER, NS_STOP} cnm_nmt_e;

	typedef struct packed {
		logic valid;
		logic [10:0] id;
		logic rtr;
		logic [3:0] dlc;
		logic [63:0] data;
	} cnm_frame_s;

	typedef struct packed {
		logic [31:0] pre;
		logic [23:0] left;
		logic fire;
	} cnm_tmr_s;

	// Maps a network state to its seven-bit code.
	function automatic logic [6:0] cnm_code(cnm_nmt_e st);
		case (st)
			NS_PREOP: cnm_code = `CNM_CODE_PREOP;
			NS_OPER: cnm_code = `CNM_CODE_OPER;
			NS_STOP: cnm_code = `CNM_CODE_STOP;
			default: cnm_code = `CNM_CODE_BOOT;
		endcase
	endfunction
endpackage

// ===== common/cnm_if.sv
// Frame-level bus link between the node and the network master.
`timescale 1ns/1ps
interface cnm_if;
	import cnm_pkg::*;
	// Frames sent by the master, always accepted by the node.
	cnm_frame_s m2n;
	logic m2n_ready;
	// Frames sent by the node, held until the master accepts them.
	cnm_frame_s n2m;
	logic n2m_ready;

	modport node (input m2n, output m2n_ready, output n2m, input n2m_ready);
	modport master (output m2n, input m2n_ready, input n2m, output n2m_ready);
endinterface

// ===== src/cnm_timer.sv
// Periodic millisecond timer with restart.
`timescale 1ns/1ps
module cnm_timer import cnm_pkg::*; #(
	parameter int TICK_CYC = `CNM_TICK_CYC
) (
	input wire logic clk, // Clock.
	input wire logic rst_b, // Synchronous reset, active low.
	input wire logic run, // Counts while high.
	input wire logic restart, // Reloads the period.
	input wire logic [23:0] limit_ms, // Period in milliseconds.
	output logic expire // One-cycle pulse per elapsed period.
);
	cnm_tmr_s s;
	cnm_tmr_s next_s;

	// Prescale to milliseconds, then count the period down and reload.
	always_comb begin
		next_s = s;
		next_s.fire = 1'b0;
		if (!run || restart) begin
			next_s.pre = 32'h0;
			next_s.left = limit_ms;
		end else if (s.pre == 32'(TICK_CYC - 1)) begin
			next_s.pre = 32'h0;
			if (s.left <= 24'h1) begin
				next_s.fire = 1'b1;
				next_s.left = limit_ms;
			end else begin
				next_s.left = s.left - 24'h1;
			end
		end else begin
			next_s.pre = s.pre + 32'h1;
		end
	end

	// Register the state.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign expire = s.fire;
endmodule

// ===== src/cnm_node.sv
// Slave node end: boot-up, guarding, life watchdog, heartbeat and PDO identifiers.
`timescale 1ns/1ps
module cnm_node import cnm_pkg::*; #(
	parameter int TICK_CYC = `CNM_TICK_CYC,
	parameter logic [15:0] EMCY_CODE = `CNM_EMCY_CODE
) (
	input wire logic REF_CLK, // Clock, 125 MHz.
	input wire logic RST_B, // Synchronous reset, active low.
	input wire logic [6:0] NODE_ID, // Node number.
	input wire logic [3:0] AVS_ADDRESS, // Register word address.
	input wire logic AVS_READ, // Read request.
	input wire logic AVS_WRITE, // Write request.
	input wire logic [31:0] AVS_WRITEDATA, // Write data.
	output logic [31:0] AVS_READDATA, // Read data.
	output logic AVS_WAITREQUEST, // Stall while the answer is prepared.
	output logic OUT_SAFE, // Outputs held in the error state or while stopped.
	cnm_if.node LINK // Bus link.
);
	typedef struct packed {
		cnm_nmt_e st;
		logic init_done;
		logic toggle;
		logic armed;
		logic life_err;
		logic p_boot;
		logic p_guard;
		logic p_emcy;
		logic p_hb;
		logic p_pdo;
		cnm_frame_s tx;
		logic [15:0] guard_ms;
		logic [7:0] life_fac;
		logic [15:0] hb_ms;
		logic tpdo_off;
		logic [10:0] tpdo_id;
		logic [3:0] tpdo_dlc;
		logic [63:0] tpdo_data;
		logic rpdo_off;
		logic [10:0] rpdo_id;
		logic [63:0] rpdo_data;
		logic rpdo_new;
		logic ack;
		logic [31:0] rdata;
	} cnm_node_s;

	cnm_node_s s;
	cnm_node_s next_s;
	logic life_run;
	logic life_restart;
	logic life_exp;
	logic hb_run;
	logic hb_exp;
	logic [23:0] life_ms;
	logic [10:0] guard_id;
	logic wr;
	logic rx_guard;
	logic rx_nmt;
	logic [63:0] rx_data;
	logic [7:0] rx_cs;

	// ==========================================================================
	// Watchdog and heartbeat timers
	assign life_ms = 24'(s.guard_ms) * 24'(s.life_fac);
	assign life_run = s.armed && s.guard_ms != 16'h0 && s.life_fac != 8'h0;
	assign life_restart = rx_guard;
	assign hb_run = s.hb_ms != 16'h0 && s.st != NS_INIT;

	cnm_timer #(.TICK_CYC(TICK_CYC)) u_life (
		.clk(REF_CLK),
		.rst_b(RST_B),
		.run(life_run),
		.restart(life_restart),
		.limit_ms(life_ms),
		.expire(life_exp)
	);

	cnm_timer #(.TICK_CYC(TICK_CYC)) u_hb (
		.clk(REF_CLK),
		.rst_b(RST_B),
		.run(hb_run),
		.restart(1'b0),
		.limit_ms({8'h00, s.hb_ms}),
		.expire(hb_exp)
	);

	// ==========================================================================
	// Receive decode; the node never refuses a frame.
	assign guard_id = `CNM_ID_GUARD_BASE + {4'h0, NODE_ID};
	assign rx_data = LINK.m2n.data;
	assign rx_cs = rx_data[7:0];
	assign rx_guard = LINK.m2n.valid && LINK.m2n.rtr && LINK.m2n.id == guard_id
		&& s.st != NS_INIT;
	assign rx_nmt = LINK.m2n.valid && !LINK.m2n.rtr && LINK.m2n.id == `CNM_ID_NMT
		&& LINK.m2n.dlc >= 4'h2 && (rx_data[15:8] == 8'h00 || rx_data[14:8] == NODE_ID)
		&& rx_data[15] == 1'b0;
	assign wr = AVS_WRITE && s.ack;

	// Next state of the whole node.
	always_comb begin
		next_s = s;
		// Register access: the answer is prepared in the first cycle.
		next_s.ack = (AVS_READ || AVS_WRITE) && !s.ack;
		case (AVS_ADDRESS)
			`CNM_REG_CTRL: next_s.rdata = {31'h0, s.init_done};
			`CNM_REG_STATUS: next_s.rdata = {21'h0, s.toggle, s.rpdo_new, s.life_err,
				1'b0, cnm_code(s.st)};
			`CNM_REG_GUARD: next_s.rdata = {16'h0, s.guard_ms};
			`CNM_REG_LIFE: next_s.rdata = {24'h0, s.life_fac};
			`CNM_REG_HB: next_s.rdata = {16'h0, s.hb_ms};
			`CNM_REG_TPDO_ID: next_s.rdata = {s.tpdo_off, 20'h0, s.tpdo_id};
			`CNM_REG_TPDO_LO: next_s.rdata = s.tpdo_data[31:0];
			`CNM_REG_TPDO_HI: next_s.rdata = s.tpdo_data[63:32];
			`CNM_REG_TPDO_CTL: next_s.rdata = {28'h0, s.tpdo_dlc};
			`CNM_REG_RPDO_ID: next_s.rdata = {s.rpdo_off, 20'h0, s.rpdo_id};
			`CNM_REG_RPDO_LO: next_s.rdata = s.rpdo_data[31:0];
			`CNM_REG_RPDO_HI: next_s.rdata = s.rpdo_data[63:32];
			default: next_s.rdata = 32'h0;
		endcase
		if (wr) begin
			case (AVS_ADDRESS)
				`CNM_REG_CTRL: begin
					next_s.init_done = AVS_WRITEDATA[0];
					if (AVS_WRITEDATA[1])
						next_s.rpdo_new = 1'b0;
					if (AVS_WRITEDATA[2])
						next_s.life_err = 1'b0;
				end
				`CNM_REG_GUARD: next_s.guard_ms = AVS_WRITEDATA[15:0];
				`CNM_REG_LIFE: next_s.life_fac = AVS_WRITEDATA[7:0];
				`CNM_REG_HB: next_s.hb_ms = AVS_WRITEDATA[15:0];
				`CNM_REG_TPDO_ID: begin
					// Only the 11-bit identifier and the off bit 31 are kept; bits 11 to 30 are dropped.
					next_s.tpdo_off = AVS_WRITEDATA[`CNM_COBID_OFF_BIT];
					next_s.tpdo_id = AVS_WRITEDATA[10:0];
				end
				`CNM_REG_TPDO_LO: next_s.tpdo_data[31:0] = AVS_WRITEDATA;
				`CNM_REG_TPDO_HI: next_s.tpdo_data[63:32] = AVS_WRITEDATA;
				`CNM_REG_TPDO_CTL: begin
					// Longer payloads are clipped to one frame.
					next_s.tpdo_dlc = (AVS_WRITEDATA[3:0] > `CNM_MAX_DLC) ?
						`CNM_MAX_DLC : AVS_WRITEDATA[3:0];
					if (AVS_WRITEDATA[`CNM_TPDO_SEND_BIT] && s.st == NS_OPER && !s.tpdo_off)
						next_s.p_pdo = 1'b1;
				end
				`CNM_REG_RPDO_ID: begin
					next_s.rpdo_off = AVS_WRITEDATA[`CNM_COBID_OFF_BIT];
					next_s.rpdo_id = AVS_WRITEDATA[10:0];
				end
				default: ;
			endcase
		end
		// Network state machine.
		case (s.st)
			NS_INIT: begin
				if (s.init_done) begin
					next_s.st = NS_PREOP;
					next_s.p_boot = 1'b1;
					next_s.toggle = 1'b0;
				end
			end
			default: begin
				if (rx_nmt) begin
					case (rx_cs)
						`CNM_CS_START: next_s.st = NS_OPER;
						`CNM_CS_STOP: next_s.st = NS_STOP;
						`CNM_CS_PREOP: next_s.st = NS_PREOP;
						`CNM_CS_RST_NODE, `CNM_CS_RST_COMM: begin
							next_s.st = NS_INIT;
							next_s.armed = 1'b0;
							next_s.p_guard = 1'b0;
							next_s.p_hb = 1'b0;
							next_s.p_pdo = 1'b0;
						end
						default: ;
					endcase
				end
			end
		endcase
		// A guarding request queues a reply and re-arms the watchdog.
		if (rx_guard) begin
			next_s.p_guard = 1'b1;
			next_s.armed = 1'b1;
			next_s.life_err = 1'b0;
		end
		// Watchdog expiry: safe outputs, emergency, back to pre-operational.
		if (life_exp && !rx_guard) begin
			next_s.life_err = 1'b1;
			next_s.p_emcy = 1'b1;
			next_s.armed = 1'b0;
			if (s.st != NS_INIT)
				next_s.st = NS_PREOP;
		end
		if (hb_exp)
			next_s.p_hb = 1'b1;
		// Received PDO, taken only while operational; arrival wins over a clear.
		if (LINK.m2n.valid && !LINK.m2n.rtr && !s.rpdo_off && s.st == NS_OPER
			&& LINK.m2n.id == s.rpdo_id) begin
			next_s.rpdo_data = rx_data;
			next_s.rpdo_new = 1'b1;
		end
		// Transmit slot: the held frame leaves when the master accepts it.
		if (s.tx.valid && LINK.n2m_ready)
			next_s.tx.valid = 1'b0;
		if (!s.tx.valid) begin
			next_s.tx.rtr = 1'b0;
			next_s.tx.data = 64'h0;
			next_s.tx.dlc = 4'h1;
			next_s.tx.id = guard_id;
			if (s.p_emcy) begin
				next_s.p_emcy = 1'b0;
				next_s.tx.valid = 1'b1;
				next_s.tx.id = `CNM_ID_EMCY_BASE + {4'h0, NODE_ID};
				next_s.tx.dlc = `CNM_MAX_DLC;
				next_s.tx.data = {48'h0, EMCY_CODE};
			end else if (s.p_boot) begin
				next_s.p_boot = 1'b0;
				next_s.tx.valid = 1'b1;
				next_s.tx.data = {56'h0, `CNM_BOOT_BYTE};
			end else if (s.p_guard) begin
				next_s.p_guard = rx_guard;
				next_s.tx.valid = 1'b1;
				next_s.tx.data = {56'h0, s.toggle, cnm_code(s.st)};
				next_s.toggle = !s.toggle;
			end else if (s.p_hb) begin
				next_s.p_hb = hb_exp;
				next_s.tx.valid = 1'b1;
				next_s.tx.data = {56'h0, 1'b0, cnm_code(s.st)};
			end else if (s.p_pdo) begin
				next_s.p_pdo = 1'b0;
				if (s.st == NS_OPER && !s.tpdo_off) begin
					next_s.tx.valid = 1'b1;
					next_s.tx.id = s.tpdo_id;
					next_s.tx.dlc = s.tpdo_dlc;
					next_s.tx.data = s.tpdo_data;
				end
			end
		end
	end

	// Register the state; PDO identifiers reset to the base identifiers, without the node number.
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			s <= '0;
			s.tpdo_id <= `CNM_ID_TPDO_BASE;
			s.rpdo_id <= `CNM_ID_RPDO_BASE;
			s.tpdo_dlc <= `CNM_MAX_DLC;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================================
	// Outputs
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !s.ack;
	assign AVS_READDATA = s.rdata;
	assign OUT_SAFE = s.life_err || s.st == NS_STOP;
	assign LINK.m2n_ready = 1'b1;
	assign LINK.n2m = s.tx;
endmodule

// ===== src/cnm_master.sv
// Network master end: commands, node guarding, own heartbeat and PDO exchange.
`timescale 1ns/1ps
module cnm_master import cnm_pkg::*; #(
	parameter int TICK_CYC = `CNM_TICK_CYC,
	parameter logic [6:0] MASTER_ID = 7'h01
) (
	input wire logic REF_CLK, // Clock, 125 MHz.
	input wire logic RST_B, // Synchronous reset, active low.
	input wire logic CMD_VALID, // Network command request.
	output logic CMD_READY, // Command taken.
	input wire logic [7:0] CMD_CS, // Command specifier.
	input wire logic [6:0] CMD_NODE, // Target node, zero for all.
	input wire logic [6:0] GUARD_NODE, // Node under guarding.
	input wire logic [15:0] GUARD_MS, // Guarding period, zero stops it.
	input wire logic [6:0] EXP_STATE, // Expected state code.
	input wire logic [15:0] HB_MS, // Own heartbeat period, zero stops it.
	input wire logic FAULT_CLR, // Clears the fault flag.
	output logic FAULT, // Slave fault seen.
	output logic [7:0] GUARD_BYTE, // Last guarding reply byte.
	input wire logic PDO_VALID, // PDO send request.
	output logic PDO_READY, // PDO taken.
	input wire logic [10:0] PDO_ID, // PDO identifier.
	input wire logic [3:0] PDO_DLC, // PDO length, at most eight.
	input wire logic [63:0] PDO_DATA, // PDO payload.
	output logic RX_VALID, // Data frame received, one cycle.
	output logic [10:0] RX_ID, // Received identifier.
	output logic [63:0] RX_DATA, // Received payload.
	cnm_if.master LINK // Bus link.
);
	typedef struct packed {
		cnm_frame_s tx;
		logic waiting;
		logic exp_tog;
		logic fault;
		logic p_rtr;
		logic p_hb;
		logic [7:0] gbyte;
		logic rx_v;
		logic [10:0] rx_id;
		logic [63:0] rx_data;
	} cnm_mst_s;

	cnm_mst_s s;
	cnm_mst_s next_s;
	logic g_exp;
	logic h_exp;
	logic is_reply;
	logic [10:0] gid;
	logic bad;

	cnm_timer #(.TICK_CYC(TICK_CYC)) u_guard (
		.clk(REF_CLK),
		.rst_b(RST_B),
		.run(GUARD_MS != 16'h0),
		.restart(1'b0),
		.limit_ms({8'h00, GUARD_MS}),
		.expire(g_exp)
	);

	cnm_timer #(.TICK_CYC(TICK_CYC)) u_hb (
		.clk(REF_CLK),
		.rst_b(RST_B),
		.run(HB_MS != 16'h0),
		.restart(1'b0),
		.limit_ms({8'h00, HB_MS}),
		.expire(h_exp)
	);

	assign gid = `CNM_ID_GUARD_BASE + {4'h0, GUARD_NODE};
	assign is_reply = LINK.n2m.valid && !LINK.n2m.rtr && LINK.n2m.id == gid;
	assign bad = LINK.n2m.data[7:0] != {s.exp_tog, EXP_STATE};
	// Commands come first, so the link slot is offered to them before PDOs.
	assign CMD_READY = !s.tx.valid;
	assign PDO_READY = !s.tx.valid && !CMD_VALID && !s.p_rtr && !s.p_hb;

	// Guarding check, transmit arbitration and receive capture.
	always_comb begin
		next_s = s;
		next_s.rx_v = 1'b0;
		if (FAULT_CLR)
			next_s.fault = 1'b0;
		if (g_exp) begin
			next_s.p_rtr = 1'b1;
			if (s.waiting)
				next_s.fault = 1'b1;
		end
		if (h_exp)
			next_s.p_hb = 1'b1;
		if (is_reply) begin
			next_s.gbyte = LINK.n2m.data[7:0];
			if (LINK.n2m.data[7:0] == `CNM_BOOT_BYTE && !s.waiting) begin
				next_s.exp_tog = 1'b0;
			end else if (s.waiting) begin
				next_s.waiting = 1'b0;
				next_s.exp_tog = !s.exp_tog;
				if (bad)
					next_s.fault = 1'b1;
			end
		end else if (LINK.n2m.valid && !LINK.n2m.rtr) begin
			next_s.rx_v = 1'b1;
			next_s.rx_id = LINK.n2m.id;
			next_s.rx_data = LINK.n2m.data;
		end
		if (s.tx.valid && LINK.m2n_ready)
			next_s.tx.valid = 1'b0;
		if (!s.tx.valid) begin
			next_s.tx.rtr = 1'b0;
			next_s.tx.valid = 1'b1;
			if (CMD_VALID) begin
				next_s.tx.id = `CNM_ID_NMT;
				next_s.tx.dlc = 4'h2;
				next_s.tx.data = {48'h0, 1'b0, CMD_NODE, CMD_CS};
			end else if (s.p_rtr) begin
				next_s.p_rtr = g_exp;
				next_s.waiting = 1'b1;
				next_s.tx.id = gid;
				next_s.tx.rtr = 1'b1;
				next_s.tx.dlc = 4'h1;
				next_s.tx.data = 64'h0;
			end else if (s.p_hb) begin
				next_s.p_hb = h_exp;
				next_s.tx.id = `CNM_ID_GUARD_BASE + {4'h0, MASTER_ID};
				next_s.tx.dlc = 4'h1;
				next_s.tx.data = {56'h0, 1'b0, `CNM_CODE_OPER};
			end else if (PDO_VALID) begin
				next_s.tx.id = PDO_ID;
				next_s.tx.dlc = (PDO_DLC > `CNM_MAX_DLC) ? `CNM_MAX_DLC : PDO_DLC;
				next_s.tx.data = PDO_DATA;
			end else begin
				next_s.tx.valid = 1'b0;
			end
		end
	end

	// Register the state.
	always_ff @(posedge REF_CLK) begin
		if (!RST_B) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign FAULT = s.fault;
	assign GUARD_BYTE = s.gbyte;
	assign RX_VALID = s.rx_v;
	assign RX_ID = s.rx_id;
	assign RX_DATA = s.rx_data;
	assign LINK.m2n = s.tx;
	assign LINK.n2m_ready = 1'b1;
endmodule

// ===== test/cnm_chk_properties.sv
// Link checker: frame-level rules on the wire between node and master.
`timescale 1ns/1ps
`include "cnm_cfg.svh"
module cnm_chk import cnm_pkg::*; #(
	parameter logic [6:0] NODE = 7'h1B
) (
	input wire logic clk, // Clock.
	input wire logic rst_b, // Reset, active low.
	input wire cnm_frame_s m2n, // Master frames.
	input wire logic m2n_ready, // Node accepts.
	input wire cnm_frame_s n2m, // Node frames.
	input wire logic n2m_ready // Master accepts.
);
	// ========
	// Helper state
	logic [10:0] gid;
	logic own, ask_in, ask_d, boot, rst_cmd, asked, alive, seen, last_t;
	assign gid = `CNM_ID_GUARD_BASE + {4'h0, NODE};
	assign own = n2m.valid && n2m.id == gid && n2m_ready;
	assign ask_in = m2n.valid && m2n.rtr && m2n.id == gid && alive;
	assign boot = own && n2m.data[7:0] == `CNM_BOOT_BYTE;
	assign rst_cmd = m2n.valid && !m2n.rtr && m2n.id == `CNM_ID_NMT
		&& m2n.data[7:0] inside {`CNM_CS_RST_NODE, `CNM_CS_RST_COMM};
	// A reset command drops the node to init, so requests are not owed until it boots again.
	// A frame in the cycle after a request was loaded before it, so it cannot be the reply.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			{ask_d, asked, alive, seen, last_t} <= 5'h00;
		end else begin
			ask_d <= ask_in;
			asked <= (asked && !own) || ask_d;
			alive <= (alive && !rst_cmd) || boot;
			seen <= !boot && (seen || (own && asked));
			last_t <= (own && asked) ? n2m.data[7] : last_t;
		end
	end
	// ========
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_reply;
		own && n2m.dlc == 4'h1 && !n2m.rtr;
	endsequence
	guard_reply_a: assert property (ask_in |-> ##[1:8] s_reply)
		else $error("guard request not answered");
	first_toggle_a: assert property (own && asked && !seen |-> !n2m.data[7])
		else $error("first toggle not zero");
	toggle_flip_a: assert property (own && asked && seen |-> n2m.data[7] != last_t)
		else $error("toggle did not invert");
	state_code_a: assert property (own && !boot |-> n2m.data[6:0] inside {7'h04, 7'h05, 7'h7F})
		else $error("bad state code");
	hb_clear_a: assert property (own && !asked |-> !n2m.data[7] && n2m.dlc == 4'h1)
		else $error("unrequested status frame malformed");
	emcy_form_a: assert property (n2m.valid && n2m.id == `CNM_ID_EMCY_BASE + {4'h0, NODE}
		|-> n2m.dlc == 4'h8 && n2m.data[15:0] == `CNM_EMCY_CODE)
		else $error("emergency frame malformed");
	node_len_a: assert property (n2m.valid |-> n2m.dlc <= `CNM_MAX_DLC)
		else $error("node frame too long");
	rtr_target_a: assert property (m2n.valid && m2n.rtr |-> m2n.id == gid && m2n_ready)
		else $error("remote request on wrong identifier");
	master_len_a: assert property (m2n.valid |-> m2n.dlc <= `CNM_MAX_DLC)
		else $error("master frame too long");
	master_hb_a: assert property (m2n.valid && !m2n.rtr && m2n.id[10:7] == 4'hE
		|-> m2n.dlc == 4'h1 && m2n.data[7:0] == {1'b0, `CNM_CODE_OPER})
		else $error("master heartbeat malformed");
endmodule

// ===== test/tb.sv
// Bench joining node and master ends, with the link checker beside them.
`timescale 1ns/1ps
`include "cnm_cfg.svh"
module tb;
	import cnm_pkg::*;
	typedef struct packed {logic [7:0] cs; logic [6:0] code;} cnm_row_s;
	localparam int TK = 4;
	localparam logic [6:0] NID = 7'h1B;
	localparam logic [10:0] GID = 11'h71B;
	localparam logic [10:0] EID = 11'h09B;
	logic clk = 0, rst_b = 0, rd = 0, wr = 0, wait_rq, out_safe, cmd_v = 0, cmd_rdy;
	logic fclr = 0, fault, pdo_v = 0, pdo_rdy, rx_v;
	logic [3:0] adr = 0, pdo_dlc = 0;
	logic [31:0] wd = 0, rdata, q;
	logic [7:0] cs = 0, gbyte;
	logic [6:0] exp_st = 7'h7F;
	logic [15:0] g_ms = 0, hb_ms = 0;
	logic [10:0] pdo_id = 0, rx_id;
	logic [63:0] pdo_d = 0, rx_d;
	cnm_frame_s fr;
	int n_mismatch = 0, n_tests = 0, cyc;
	cnm_row_s rows [4] = '{'{8'h01, 7'h05}, '{8'h02, 7'h04}, '{8'h80, 7'h7F}, '{8'h01, 7'h05}};
	cnm_if cnm_if_i();
	cnm_node #(.TICK_CYC(TK)) cnm_node_i(.REF_CLK(clk), .RST_B(rst_b), .NODE_ID(NID),
		.AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_rq), .OUT_SAFE(out_safe), .LINK(cnm_if_i.node));
	cnm_master #(.TICK_CYC(TK)) cnm_master_i(.REF_CLK(clk), .RST_B(rst_b), .CMD_VALID(cmd_v),
		.CMD_READY(cmd_rdy), .CMD_CS(cs), .CMD_NODE(NID), .GUARD_NODE(NID), .GUARD_MS(g_ms),
		.EXP_STATE(exp_st), .HB_MS(hb_ms), .FAULT_CLR(fclr), .FAULT(fault), .GUARD_BYTE(gbyte),
		.PDO_VALID(pdo_v), .PDO_READY(pdo_rdy), .PDO_ID(pdo_id), .PDO_DLC(pdo_dlc),
		.PDO_DATA(pdo_d), .RX_VALID(rx_v), .RX_ID(rx_id), .RX_DATA(rx_d), .LINK(cnm_if_i.master));
	cnm_chk #(.NODE(NID)) cnm_chk_i(.clk(clk), .rst_b(rst_b), .m2n(cnm_if_i.m2n),
		.m2n_ready(cnm_if_i.m2n_ready), .n2m(cnm_if_i.n2m), .n2m_ready(cnm_if_i.n2m_ready));
	// 125 MHz clock.
	initial begin
		forever #4 clk = ~clk;
	end
	// ========
	// Tasks
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic lost(input string nm);
		n_mismatch++;
		$display("[ERR] %s expected done seen timeout", nm);
		wrap_up();
	endtask
	// One bus cycle; read data is taken at the edge that sees waitrequest low, then released.
	task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		do begin @(posedge clk); k++; end while (wait_rq !== 1'b0 && k < 20);
		if (k == 20) lost("bus");
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_tx(input logic [10:0] id);
		cyc = 0;
		do begin @(negedge clk); cyc++; end
			while (!(cnm_if_i.n2m.valid === 1'b1 && cnm_if_i.n2m.id === id) && cyc < 400);
		if (cyc == 400) lost("frame");
		fr = cnm_if_i.n2m;
		@(posedge clk);
	endtask
	task automatic no_tx(input logic [10:0] id, input int n);
		int hit;
		hit = 0;
		repeat (n) begin
			@(negedge clk);
			hit += int'(cnm_if_i.n2m.valid === 1'b1 && cnm_if_i.n2m.id === id);
		end
		chk("quiet", 64'h0, 64'(hit));
		@(posedge clk);
	endtask
	// The command and PDO requests hold until the master takes them.
	task automatic cmd(input logic [7:0] c);
		int k;
		k = 0;
		cs <= c;
		cmd_v <= 1'b1;
		do begin @(negedge clk); k++; end while (cmd_rdy !== 1'b1 && k < 50);
		if (k == 50) lost("cmd");
		@(posedge clk);
		cmd_v <= 1'b0;
		@(posedge clk);
	endtask
	task automatic pdo();
		int k;
		k = 0;
		pdo_v <= 1'b1;
		do begin @(negedge clk); k++; end while (pdo_rdy !== 1'b1 && k < 50);
		if (k == 50) lost("pdo");
		@(posedge clk);
		pdo_v <= 1'b0;
		@(posedge clk);
	endtask
	// ========
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk("reset", 0, {rdata, out_safe, fault, rx_v, cnm_if_i.n2m.valid, cnm_if_i.m2n.valid});
		@(posedge clk);
		avs(0, `CNM_REG_TPDO_ID, 0);
		chk("tpdo id", 32'h180, q);
		avs(1, 4'hF, 32'hFFFFFFFF);
		avs(0, 4'hF, 0);
		chk("unmapped", 0, q);
		avs(1, `CNM_REG_CTRL, 1);
		wait_tx(GID);
		chk("boot", 12'h100, {fr.dlc, fr.data[7:0]});
		avs(0, `CNM_REG_STATUS, 0);
		chk("state", 7'h7F, q[6:0]);
		g_ms <= 16'h5;
		wait_tx(GID);
		repeat (2) @(posedge clk);
		chk("guard byte", 8'h7F, gbyte);
		wait_tx(GID);
		repeat (2) @(posedge clk);
		chk("guard byte", 8'hFF, gbyte);
		chk("fault", 0, fault);
		// Start, stop, pre-operational and start again, then the reply code each should give.
		foreach (rows[i]) begin
			exp_st <= rows[i].code;
			cmd(rows[i].cs);
			avs(0, `CNM_REG_STATUS, 0);
			chk("state", rows[i].code, q[6:0]);
			wait_tx(GID);
			wait_tx(GID);
			chk("reply", rows[i].code, fr.data[6:0]);
		end
		exp_st <= 7'h04;
		wait_tx(GID);
		repeat (2) @(posedge clk);
		chk("fault", 1, fault);
		exp_st <= 7'h05;
		fclr <= 1'b1;
		@(posedge clk);
		fclr <= 1'b0;
		avs(1, `CNM_REG_TPDO_LO, 32'h44332211);
		avs(1, `CNM_REG_TPDO_HI, 32'h88776655);
		avs(1, `CNM_REG_TPDO_ID, 32'hFFFFF981);
		avs(0, `CNM_REG_TPDO_ID, 0);
		chk("cob id", 32'h80000181, q);
		avs(1, `CNM_REG_TPDO_CTL, 32'h108);
		no_tx(11'h181, 20);
		avs(1, `CNM_REG_TPDO_ID, 32'h7FFFF981);
		avs(1, `CNM_REG_TPDO_CTL, 32'h108);
		wait_tx(11'h181);
		chk("tpdo", 64'h8877665544332211, fr.data);
		@(negedge clk);
		chk("rx valid", 1, rx_v);
		repeat (2) @(posedge clk);
		chk("rx", {11'h181, 64'h8877665544332211}, {rx_id, rx_d});
		pdo_id <= 11'h200;
		pdo_dlc <= 4'h8;
		pdo_d <= 64'h0123456789ABCDEF;
		pdo();
		repeat (4) @(posedge clk);
		avs(0, `CNM_REG_RPDO_HI, 0);
		chk("rpdo", 32'h01234567, q);
		exp_st <= 7'h7F;
		cmd(8'h80);
		avs(1, `CNM_REG_TPDO_CTL, 32'h108);
		no_tx(11'h181, 20);
		exp_st <= 7'h05;
		cmd(8'h01);
		// Life time 2 ms x 3 = 24 cycles; a 20 cycle guard period keeps it fed.
		avs(1, `CNM_REG_GUARD, 2);
		avs(1, `CNM_REG_LIFE, 3);
		repeat (80) @(posedge clk);
		chk("safe", 0, out_safe);
		g_ms <= 16'h0;
		wait_tx(EID);
		chk("emcy", 16'h1000, fr.data[15:0]);
		repeat (2) @(posedge clk);
		chk("safe", 1, out_safe);
		avs(0, `CNM_REG_STATUS, 0);
		chk("status", 9'h17F, q[8:0]);
		exp_st <= 7'h7F;
		g_ms <= 16'h5;
		wait_tx(GID);
		avs(0, `CNM_REG_STATUS, 0);
		chk("life err", 0, {q[8], out_safe});
		g_ms <= 16'h0;
		avs(1, `CNM_REG_LIFE, 0);
		repeat (80) @(posedge clk);
		chk("safe", 0, out_safe);
		hb_ms <= 16'h2;
		avs(1, `CNM_REG_HB, 2);
		wait_tx(GID);
		wait_tx(GID);
		chk("hb period", 2 * TK, cyc);
		chk("hb byte", 12'h17F, {fr.dlc, fr.data[7:0]});
		avs(1, `CNM_REG_HB, 0);
		no_tx(GID, 40);
		cmd(8'h81);
		wait_tx(GID);
		chk("reboot", 8'h00, fr.data[7:0]);
		g_ms <= 16'h5;
		wait_tx(GID);
		repeat (2) @(posedge clk);
		chk("guard byte", 8'h7F, gbyte);
		wrap_up();
	end
endmodule
